// ---- rtl/period_match_timer8_defs.vh ----
// Constants for the period match timer: offsets, field positions, reset values, timing.
`ifndef PERIOD_MATCH_TIMER8_DEFS_VH
`define PERIOD_MATCH_TIMER8_DEFS_VH

// Register indices as printed; byte address is four times the index.
`define COUNT_REG_INDEX      8'h11
`define CONTROL_REG_INDEX    8'h12
`define PERIOD_REG_INDEX     8'h13
`define STATUS_REG_INDEX     8'h14
`define MASK_REG_INDEX       8'h15
`define COUNT_REG_ADDR       12'h044
`define CONTROL_REG_ADDR     12'h048
`define PERIOD_REG_ADDR      12'h04C
`define STATUS_REG_ADDR      12'h050
`define MASK_REG_ADDR        12'h054

// Control field positions.
`define PRESCALE_LSB         0
`define PRESCALE_MSB         1
`define RUN_BIT              2
`define POSTSCALE_LSB        3
`define POSTSCALE_MSB        6

// Reset values.
`define COUNT_RESET          8'h00
`define PERIOD_RESET         8'hFF
`define CONTROL_RESET        7'h00

// Last phase of the four-phase cycle; the instruction clock strobe fires on it.
`define INSTR_CLOCK_DIVIDE   2'h3
// Prescaler terminal counts for divide by 1, 4 and 16.
`define PRESCALE_TC_DIV1     4'h0
`define PRESCALE_TC_DIV4     4'h3
`define PRESCALE_TC_DIV16    4'hF

`endif

// ---- rtl/instr_clock_strobe.v ----
// Strobe generator that marks one system clock in four as an instruction clock.
`include "period_match_timer8_defs.vh"
`timescale 1ns/1ps
module instr_clock_strobe (
  input  wire       ref_clk,  // System clock.
  input  wire       rst,      // Asynchronous reset, active high.
  output reg        strobe    // One-cycle pulse every fourth clock.
);

  reg [1:0] phase;

  // Free-running phase counter; strobe fires on the last phase.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase  <= 2'h0;
      strobe <= 1'b0;
    end else begin
      phase  <= phase + 2'h1;
      strobe <= (phase == `INSTR_CLOCK_DIVIDE);
    end
  end

endmodule

// ---- rtl/period_match_timer8.v ----
// Eight-bit period match timer with prescaler, postscaler and APB register access.
//
// Local design decision: the APB slave port.
`include "period_match_timer8_defs.vh"
`timescale 1ns/1ps
module period_match_timer8 (
  input  wire        ref_clk,   // System clock, 50 MHz.
  input  wire        rst,       // Asynchronous reset, active high.
  input  wire        psel,      // APB select.
  input  wire        penable,   // APB access phase.
  input  wire        pwrite,    // APB direction, high for write.
  input  wire [11:0] paddr,     // APB byte address.
  input  wire [31:0] pwdata,    // APB write data.
  output reg  [31:0] prdata,    // APB read data.
  output reg         pready,    // APB ready.
  output reg         pslverr,   // APB error for unmapped address.
  output reg         irq        // Level interrupt, unmasked flag set.
);

  reg  [7:0] count_register;
  reg  [7:0] period_register;
  reg  [6:0] timer_control;
  reg        match_interrupt_flag;
  reg        irq_mask;
  reg  [3:0] prescale_count;
  reg  [3:0] postscale_count;
  wire       instr_tick;
  wire [1:0] prescale_select;
  wire [3:0] postscale_select;
  wire       run_bit;
  reg  [3:0] prescale_tc;
  wire       prescale_out;
  wire       match;
  wire       post_out;
  wire       setup;
  wire       wr_count;
  wire       wr_control;
  wire       wr_period;
  wire       wr_status;
  wire       wr_mask;
  wire       addr_ok;
  reg  [31:0] next_prdata;

  // Instruction clock strobe, one system clock in four.
  instr_clock_strobe u_strobe (
    .ref_clk (ref_clk),
    .rst     (rst),
    .strobe  (instr_tick)
  );

  // Control fields.
  assign prescale_select  = timer_control[`PRESCALE_MSB:`PRESCALE_LSB];
  assign postscale_select = timer_control[`POSTSCALE_MSB:`POSTSCALE_LSB];
  assign run_bit          = timer_control[`RUN_BIT];

  // Terminal count of the prescaler for the selected ratio.
  always @* begin
    case (prescale_select)
      2'h0:    prescale_tc = `PRESCALE_TC_DIV1;
      2'h1:    prescale_tc = `PRESCALE_TC_DIV4;
      default: prescale_tc = `PRESCALE_TC_DIV16;
    endcase
  end

  // Prescaler output, compare and postscaler output.
  assign prescale_out = run_bit && instr_tick && (prescale_count >= prescale_tc);
  assign match        = (count_register == period_register);
  assign post_out     = prescale_out && match &&
                        (postscale_count >= postscale_select);

  // APB decode; writes act in the access phase, one cycle after setup.
  assign setup      = psel && !penable;
  assign addr_ok    = (paddr == `COUNT_REG_ADDR) || (paddr == `CONTROL_REG_ADDR) ||
                      (paddr == `PERIOD_REG_ADDR) || (paddr == `STATUS_REG_ADDR) ||
                      (paddr == `MASK_REG_ADDR);
  assign wr_count   = psel && penable && pready && pwrite && (paddr == `COUNT_REG_ADDR);
  assign wr_control = psel && penable && pready && pwrite && (paddr == `CONTROL_REG_ADDR);
  assign wr_period  = psel && penable && pready && pwrite && (paddr == `PERIOD_REG_ADDR);
  assign wr_status  = psel && penable && pready && pwrite && (paddr == `STATUS_REG_ADDR);
  assign wr_mask    = psel && penable && pready && pwrite && (paddr == `MASK_REG_ADDR);

  // Prescaler counter, cleared while stopped.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prescale_count <= 4'h0;
    end else if (!run_bit) begin
      prescale_count <= 4'h0;
    end else if (instr_tick) begin
      if (prescale_count >= prescale_tc) begin
        prescale_count <= 4'h0;
      end else begin
        prescale_count <= prescale_count + 4'h1;
      end
    end
  end

  // Postscaler counter, one step per match, cleared while stopped.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      postscale_count <= 4'h0;
    end else if (!run_bit) begin
      postscale_count <= 4'h0;
    end else if (prescale_out && match) begin
      if (post_out) begin
        postscale_count <= 4'h0;
      end else begin
        postscale_count <= postscale_count + 4'h1;
      end
    end
  end

  // Count register; a software write while running wins over an increment.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_register <= `COUNT_RESET;
    end else if (wr_count && run_bit) begin
      count_register <= pwdata[7:0];
    end else if (prescale_out) begin
      if (match) begin
        count_register <= 8'h00;
      end else begin
        count_register <= count_register + 8'h01;
      end
    end
  end

  // Period and control registers; a control write does not touch the count.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      period_register <= `PERIOD_RESET;
      timer_control   <= `CONTROL_RESET;
      irq_mask        <= 1'b0;
    end else begin
      if (wr_period) begin
        period_register <= pwdata[7:0];
      end
      if (wr_control) begin
        timer_control <= pwdata[6:0];
      end
      if (wr_mask) begin
        irq_mask <= pwdata[0];
      end
    end
  end

  // Sticky match flag; a new pulse wins over a write-one clear.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      match_interrupt_flag <= 1'b0;
    end else begin
      if (post_out) begin
        match_interrupt_flag <= 1'b1;
      end else if (wr_status && pwdata[0]) begin
        match_interrupt_flag <= 1'b0;
      end
    end
  end

  // Read data multiplexer.
  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `COUNT_REG_ADDR:   next_prdata = {24'h000000, count_register};
      `CONTROL_REG_ADDR: next_prdata = {25'h0000000, timer_control};
      `PERIOD_REG_ADDR:  next_prdata = {24'h000000, period_register};
      `STATUS_REG_ADDR:  next_prdata = {31'h00000000, match_interrupt_flag};
      `MASK_REG_ADDR:    next_prdata = {31'h00000000, irq_mask};
      default:           next_prdata = 32'h0000_0000;
    endcase
  end

  // APB slave: ready one cycle after setup, data and error registered.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= !addr_ok;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Interrupt output, registered.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (match_interrupt_flag || post_out) && irq_mask;
    end
  end

endmodule

// ---- bench/period_match_timer8_monitor.sv ----
// Checker of bus timing, read-back and interrupt rules of the period match timer.
`timescale 1ns/1ps
`include "period_match_timer8_defs.vh"
module period_match_timer8_monitor (
  input logic        ref_clk,  // System clock.
  input logic        rst,      // Reset, active high.
  input logic        psel,     // Select.
  input logic        penable,  // Access phase.
  input logic        pwrite,   // Direction.
  input logic [11:0] paddr,    // Byte address.
  input logic [31:0] pwdata,   // Write data.
  input logic [31:0] prdata,   // Read data.
  input logic        pready,   // Ready.
  input logic        pslverr,  // Error.
  input logic        irq       // Interrupt.
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A transfer is a setup cycle followed by an answered access cycle.
  sequence setup_s; psel && !penable; endsequence
  sequence done_s; psel && penable && pready; endsequence
  wire mapped = paddr >= `COUNT_REG_ADDR && paddr <= `MASK_REG_ADDR && paddr[1:0] == 2'h0;
  wire rd_done = psel && penable && pready && !pwrite;
  chk_ready_after_setup: assert property (setup_s |=> done_s)
    else $error("no answer after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_needs_setup: assert property (!(psel && !penable) |=> !pready)
    else $error("ready without setup");
  chk_error_unmapped: assert property (done_s and !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_error_mapped: assert property (done_s and mapped |-> !pslverr)
    else $error("mapped access refused");
  chk_control_top_zero: assert property (rd_done && paddr == `CONTROL_REG_ADDR |->
    prdata[31:7] == 25'h0) else $error("control top bit not zero");
  chk_data_upper_zero: assert property (rd_done && mapped |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_mask_off_irq: assert property (done_s and pwrite && paddr == `MASK_REG_ADDR &&
    !pwdata[0] |=> ##1 !irq) else $error("irq high while masked");
endmodule
bind period_match_timer8 period_match_timer8_monitor period_match_timer8_monitor_inst (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq));

// ---- bench/tb_top.sv ----
// Self-checking bench for the period match timer.
`timescale 1ns/1ps
`include "period_match_timer8_defs.vh"
module tb_top;
  logic        ref_clk = 1'b0;  // Clock.
  logic        rst = 1'b1;      // Reset.
  logic        psel = 1'b0;     // Select.
  logic        penable = 1'b0;  // Access phase.
  logic        pwrite = 1'b0;   // Direction.
  logic [11:0] paddr = 12'h0;   // Address.
  logic [31:0] pwdata = 32'h0;  // Write data.
  logic [31:0] prdata;          // Read data.
  logic        pready;          // Ready.
  logic        pslverr;         // Error.
  logic        irq;             // Interrupt.
  logic [31:0] rd;              // Last read data.
  logic [31:0] v;               // Saved count.
  logic        er;              // Last error.
  int          failures = 0;    // Mismatches.
  int          compares = 0;    // Comparisons.
  int          cyc = 0;         // Cycle counter.
  int          t0;              // Start cycle.
  int          div;             // Prescale ratio.
  period_match_timer8 period_match_timer8_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  // Clock and cycle count.
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Compares a value.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Compares against a range.
  task automatic chk_in(input logic [31:0] g, input int lo, input int hi);
    compares++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: got %0d want %0d..%0d", $time, g, lo, hi);
    end
  endtask
  // One bus transfer; the answer is taken at the edge where ready is seen.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (n >= 50) begin
      failures++;
      results();
    end
  endtask
  // Polls the status register until the match flag is seen.
  task automatic wait_flag;
    int n;
    n = 0;
    do begin
      bus(1'b0, `STATUS_REG_ADDR, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 300);
    if (n >= 300) begin
      failures++;
      results();
    end
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, `COUNT_REG_ADDR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, `PERIOD_REG_ADDR, 32'h0);
    chk(rd, 32'hFF);
    bus(1'b0, `CONTROL_REG_ADDR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `CONTROL_REG_ADDR, 32'hFB);
    bus(1'b0, `CONTROL_REG_ADDR, 32'h0);
    chk(rd, 32'h7B);
    bus(1'b1, `COUNT_REG_ADDR, 32'h55);
    bus(1'b0, `COUNT_REG_ADDR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `PERIOD_REG_ADDR, 32'h5A);
    bus(1'b0, `PERIOD_REG_ADDR, 32'h0);
    chk(rd, 32'h5A);
    bus(1'b0, 12'h0FC, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test registers done");
    // Every prescale code: about ten steps in forty ratio-scaled ticks.
    for (int k = 0; k < 4; k++) begin
      div = (k == 0) ? 1 : (k == 1) ? 4 : 16;
      bus(1'b1, `CONTROL_REG_ADDR, 32'h0);
      bus(1'b1, `CONTROL_REG_ADDR, 32'h4 | k);
      bus(1'b1, `COUNT_REG_ADDR, 32'h0);
      repeat (40 * div) @(posedge ref_clk);
      bus(1'b0, `COUNT_REG_ADDR, 32'h0);
      chk_in(rd, 9, 11);
    end
    bus(1'b1, `CONTROL_REG_ADDR, 32'h3);
    bus(1'b0, `COUNT_REG_ADDR, 32'h0);
    v = rd;
    chk_in(v, 9, 12);
    repeat (200) @(posedge ref_clk);
    bus(1'b0, `COUNT_REG_ADDR, 32'h0);
    chk(rd, v);
    $display("test prescale done");
    // Match spacing for the smallest and largest postscale field.
    bus(1'b1, `PERIOD_REG_ADDR, 32'h3);
    for (int p = 0; p < 16; p += 15) begin
      bus(1'b1, `CONTROL_REG_ADDR, 32'h0);
      bus(1'b1, `CONTROL_REG_ADDR, (p << 3) | 32'h4);
      bus(1'b1, `COUNT_REG_ADDR, 32'h0);
      bus(1'b1, `STATUS_REG_ADDR, 32'h1);
      wait_flag();
      t0 = cyc;
      bus(1'b1, `STATUS_REG_ADDR, 32'h1);
      wait_flag();
      chk_in(cyc - t0, 16 * (p + 1) - 4, 16 * (p + 1) + 4);
      if (p == 0) begin
        repeat (50) @(posedge ref_clk);
        bus(1'b0, `STATUS_REG_ADDR, 32'h0);
        chk(rd, 32'h1);
      end
    end
    bus(1'b1, `MASK_REG_ADDR, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, `STATUS_REG_ADDR, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, `MASK_REG_ADDR, 32'h0);
    $display("test match done");
    results();
  end
endmodule
